// *** inc/pcx_pkg.sv ***
package pcx_pkg;
   localparam int PCX_NPINS      = 16;
   localparam int PCX_NSIG       = 8;
   localparam int PCX_PIN_W      = 4;
   // Peripheral signal slots in priority order (slot 0 highest)
   localparam int PCX_SIG_TX     = 0;
   localparam int PCX_SIG_RX     = 1;
   localparam int PCX_SIG_SCK    = 2;
   localparam int PCX_SIG_MISO   = 3;
   localparam int PCX_SIG_MOSI   = 4;
   localparam int PCX_SIG_SEL    = 5;
   localparam int PCX_SIG_CMP    = 6;
   localparam int PCX_SIG_CLKOUT = 7;
   // Select mode encoding of the SPI control
   localparam logic [1:0] PCX_SEL_3WIRE = 2'h0;
   // Reset values
   localparam logic [15:0] PCX_INMODE_RST = 16'hffff;
   localparam logic [15:0] PCX_ZERO16     = 16'h0000;
   localparam logic [7:0]  PCX_ZERO8      = 8'h00;
   localparam logic [3:0]  PCX_ZERO4      = 4'h0;
   localparam logic        PCX_ZERO1      = 1'b0;
endpackage

// *** verilog/pcx_crossbar.sv ***
`timescale 1ns/1ps
// Behaviour
// - Port latch reads the synchronised pin state of digital pins regardless of crossbar setup; analog pins read zero.
// - Enabled peripherals routed onto up to 16 pins by fixed priority.
// - Each pin output is open-drain or push-pull by its output mode bit.
// - Analog pin has pull-up, output driver and input receiver disabled.
// - Input mode bit 1 means digital, 0 means analog.
// - After reset every pin is a digital input.
// - Pull-up disable low enables pull-ups on open-drain pins only.
// - Pull-up off when pin drives 0 or pin is analog.
// - Routing a peripheral never changes the pin output mode.
// - Crossbar enable bit set to 1 activates routing.
// - Crossbar disabled makes all pins plain port inputs, selections ignored.
// - All output drivers off while crossbar disabled.
// - Slave-select routing depends on the SPI select mode.
// - Three-wire mode leaves slave-select unmapped; other modes map it.
module pcx_crossbar
   import pcx_pkg::*;
#(
   parameter int NPINS = PCX_NPINS,
   parameter int NSIG  = PCX_NSIG
) (
   input  wire logic             mclk,
   input  wire logic             rst_b,
   input  wire logic [NPINS-1:0] port_input_mode,
   input  wire logic [NPINS-1:0] port_output_mode,
   input  wire logic [NPINS-1:0] port_skip_mask,
   input  wire logic [NPINS-1:0] port_out_latch,
   input  wire logic [NSIG-1:0]  periph_select,
   input  wire logic             crossbar_enable_bit,
   input  wire logic             weak_pullup_disable,
   input  wire logic             select_mode_hi,
   input  wire logic             select_mode_lo,
   input  wire logic [NSIG-1:0]  periph_out,
   input  wire logic [NSIG-1:0]  periph_oe,
   output logic [NSIG-1:0]       periph_in,
   input  wire logic [NPINS-1:0] pin_in,
   output logic [NPINS-1:0]      pin_out,
   output logic [NPINS-1:0]      pin_oe,
   output logic [NPINS-1:0]      pin_pullup,
   output logic [NPINS-1:0]      port_read
);

   logic [NPINS-1:0] sync1_reg;
   logic [NPINS-1:0] sync1_next;
   logic [NPINS-1:0] sync2_reg;
   logic [NPINS-1:0] sync2_next;
   logic [NPINS-1:0] pin_out_reg;
   logic [NPINS-1:0] pin_out_next;
   logic [NPINS-1:0] pin_oe_reg;
   logic [NPINS-1:0] pin_oe_next;
   logic [NPINS-1:0] pullup_reg;
   logic [NPINS-1:0] pullup_next;
   logic [NSIG-1:0]  pin_in_reg;
   logic [NSIG-1:0]  pin_in_next;
   logic [NSIG-1:0]  sig_req;
   logic [NSIG-1:0]  sig_hit;
   logic [PCX_PIN_W-1:0] sig_pin [NSIG];

   // Two-flop synchroniser next values; only the second stage feeds logic
   always_comb begin
      sync1_next = pin_in;
      sync2_next = sync1_reg;
   end

   // Two-flop synchroniser; samples every pin ungated, input mode applied at readback
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sync1_reg <= PCX_ZERO16;
         sync2_reg <= PCX_ZERO16;
      end else begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
      end
   end

   // Port latch readback, analog pins read zero
   assign port_read = sync2_reg & port_input_mode;

   // Requested signals; slave-select only outside three-wire mode
   always_comb begin
      sig_req = periph_select;
      if ({select_mode_hi, select_mode_lo} == PCX_SEL_3WIRE) begin
         sig_req[PCX_SIG_SEL] = 1'b0;
      end
   end

   // Priority decoder
   always_comb begin
      logic [NPINS-1:0] taken;
      taken = port_skip_mask;
      sig_hit = PCX_ZERO8;
      for (int s = 0; s < NSIG; s++) begin
         sig_pin[s] = PCX_ZERO4;
      end
      for (int s = 0; s < NSIG; s++) begin
         for (int p = NPINS - 1; p >= 0; p--) begin
            if (sig_req[s] && !taken[p]) begin
               sig_pin[s] = PCX_PIN_W'(p);
               sig_hit[s] = 1'b1;
            end
         end
         if (sig_hit[s]) begin
            taken[sig_pin[s]] = 1'b1;
         end
      end
   end

   // Per-pin drive source: routed peripheral, else the port latch
   for (genvar p = 0; p < NPINS; p++) begin : g_pin
      logic drv_val;
      logic drv_en;
      logic drv_low;
      always_comb begin
         drv_val = port_out_latch[p];
         drv_en  = 1'b1;
         for (int s = 0; s < NSIG; s++) begin
            if (sig_hit[s] && sig_pin[s] == PCX_PIN_W'(p)) begin
               drv_val = periph_out[s];
               drv_en  = periph_oe[s];
            end
         end
         if (!crossbar_enable_bit || !port_input_mode[p]) begin
            drv_en = 1'b0;
         end
      end
      // Open-drain only pulls low; push-pull drives both levels
      assign drv_low         = drv_en && !drv_val;
      assign pin_out_next[p] = drv_val;
      assign pin_oe_next[p]  = port_output_mode[p] ? drv_en : drv_low;
      assign pullup_next[p]  = !weak_pullup_disable && !port_output_mode[p]
                               && port_input_mode[p] && !drv_low;
   end

   // Peripheral input next values
   always_comb begin
      pin_in_next = PCX_ZERO8;
      for (int s = 0; s < NSIG; s++) begin
         if (crossbar_enable_bit && sig_hit[s]) begin
            pin_in_next[s] = port_read[sig_pin[s]];
         end
      end
   end

   // Outputs registered; reset leaves all pins digital inputs
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pin_out_reg <= PCX_ZERO16;
         pin_oe_reg  <= PCX_ZERO16;
         pullup_reg  <= PCX_ZERO16;
         pin_in_reg  <= PCX_ZERO8;
      end else begin
         pin_out_reg <= pin_out_next;
         pin_oe_reg  <= pin_oe_next;
         pullup_reg  <= pullup_next;
         pin_in_reg  <= pin_in_next;
      end
   end

   assign pin_out    = pin_out_reg;
   assign pin_oe     = pin_oe_reg;
   assign pin_pullup = pullup_reg;
   assign periph_in  = pin_in_reg;

endmodule

// *** tb/pcx_crossbar_properties.sv ***
`timescale 1ns/1ps
module pcx_crossbar_chk
   import pcx_pkg::*;
#(
   parameter int NPINS = PCX_NPINS,
   parameter int NSIG  = PCX_NSIG
) (
   input wire logic             mclk, rst_b, crossbar_enable_bit,
   input wire logic [NSIG-1:0]  periph_select,
   input wire logic [NPINS-1:0] port_input_mode, port_output_mode, port_out_latch,
   input wire logic [NPINS-1:0] pin_in, pin_out, pin_oe, pin_pullup, port_read
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   a_off_no_drive: assert property (!$past(crossbar_enable_bit) |-> !pin_oe)
      else $error("driver on with crossbar off");
   a_analog_quiet: assert property (($past(~port_input_mode) & (pin_oe | pin_pullup)) == '0)
      else $error("analog pin driven or pulled");
   a_analog_reads: assert property ((port_read & ~port_input_mode) == '0)
      else $error("analog pin reads one");
   a_pp_no_pull: assert property (($past(port_output_mode) & pin_pullup) == '0)
      else $error("pull-up on push-pull pin");
   a_pull_drive_low: assert property ((pin_pullup & pin_oe & ~pin_out) == '0)
      else $error("pull-up while driving low");
   a_read_sync: assert property ($past(rst_b, 2) |->
      port_read == ($past(pin_in, 2) & port_input_mode))
      else $error("readback lost pin state");
   a_gpio_drive: assert property ($past(crossbar_enable_bit && periph_select == '0) |->
      pin_oe == $past(port_input_mode & (port_output_mode | ~port_out_latch)))
      else $error("gpio drive wrong");
endmodule
bind pcx_crossbar pcx_crossbar_chk #(.NPINS(NPINS), .NSIG(NSIG)) chk_u (.*);

// *** tb/pcx_board.sv ***
`timescale 1ns/1ps
module pcx_board (
   input  wire logic        mclk,
   input  wire logic [15:0] drv, oe, pull, ext_en, ext_val,
   output logic [15:0]      pin
);
   logic tog = 1'b0;
   // Floating pins flip every cycle so a stale level never reads back
   always @(posedge mclk) tog <= ~tog;
   // Device drive wins, then the board driver, then the weak pull-up
   assign pin = (oe & drv) | (~oe & ext_en & ext_val) | (~oe & ~ext_en & (pull | {16{tog}}));
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
   import pcx_pkg::*;
   logic        mclk, rst_b, ena, pud, smh, sml;
   logic [15:0] inm, outm, skip, latch, ext_en, ext_val, pin_in, pin_out, pin_oe, pull, rd;
   logic [7:0]  sel, pout, poe, pin8;
   int          num_errors = 0, comparisons = 0;
   pcx_crossbar dut_u (.mclk(mclk), .rst_b(rst_b), .port_input_mode(inm),
      .port_output_mode(outm), .port_skip_mask(skip), .port_out_latch(latch),
      .periph_select(sel), .crossbar_enable_bit(ena), .weak_pullup_disable(pud),
      .select_mode_hi(smh), .select_mode_lo(sml), .periph_out(pout), .periph_oe(poe),
      .periph_in(pin8), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .pin_pullup(pull), .port_read(rd));
   pcx_board brd_u (.mclk(mclk), .drv(pin_out), .oe(pin_oe), .pull(pull), .ext_en(ext_en),
      .ext_val(ext_val), .pin(pin_in));
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   task step(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         num_errors++;
      end
   endtask
   task end_sim;
      $display("errors=%0d comparisons=%0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task t_reset;
      step(4);
      chk(pin_oe, PCX_ZERO16);
      chk(pull, 16'hffff);
      chk(rd, 16'ha5a5);
   endtask
   task t_route;
      logic [15:0] m;
      logic [7:0]  e;
      int          p;
      {outm, skip, sel} = {16'hffff, 16'h0005, 8'hff};
      step(1);
      ena = 1'b1;
      for (int md = 0; md < 4; md++) begin
         {smh, sml} = md[1:0];
         e = (md == 0) ? 8'hdf : 8'hff;
         {m, p} = '0;
         for (int s = 0; s < 8; s++) if (e[s]) begin
            while (skip[p] || m[p]) p++;
            m[p] = 1'b1;
         end
         step(4);
         chk(pin_out, m);
         chk(pin_oe, 16'hffff);
         chk({8'h00, pin8}, {8'h00, e});
      end
      ena = 1'b0;
      step(4);
      chk(pin_oe, PCX_ZERO16);
      chk({8'h00, pin8}, PCX_ZERO16);
   endtask
   task t_analog;
      {inm, outm, latch, skip, ext_en} = {16'hff00, 16'h0, 16'hfdff, 16'h00ff, 16'h00ff};
      {sel, ena} = {8'h00, 1'b1};
      step(4);
      chk(pin_oe, 16'h0200);
      chk(pull, 16'hfd00);
      chk(rd, 16'hfd00);
      pud = 1'b1;
      step(4);
      chk(pull, PCX_ZERO16);
      {pud, outm} = {1'b0, 16'hffff};
      step(4);
      chk(pin_oe, 16'hff00);
      chk(pull, PCX_ZERO16);
   endtask
   initial begin
      {rst_b, ena, pud, smh, sml, sel, pout, poe} = {5'h00, 8'h00, 8'hff, 8'hff};
      {inm, outm, skip, latch, ext_en, ext_val} = {PCX_INMODE_RST, 48'h0, 16'hffff, 16'ha5a5};
      step(3);
      rst_b = 1'b1;
      t_reset;
      t_route;
      t_analog;
      end_sim;
   end
endmodule
